//--- logic/pbc_base_counter16.sv
// How it works
// RL1 - an external count passes the prescaler first and only its output is brought onto the internal phases.
// RL2 - the prescaler output is sampled twice per instruction cycle and a change between samples advances the count.
// RL3 - the count moves between three and seven oscillator periods after the chosen pin edge.
// RL4 - the sixteen-bit count is seen as a low and a high byte at separate addresses, one access per cycle.
// RL5 - writing a byte stops that byte from advancing in the next instruction cycle while the other byte runs on.
// RL6 - a write to either count byte clears the prescaler.
// RL7 - software loads sixteen bits by writing low then high back to back with interrupts off.
// RL8 - software reading sixteen bits re-reads both bytes if the low byte wrapped in between.
// RL9 - the prescale setting may change while running, best after clearing the prescaler.
// RL10 - the count bytes have no reset value and keep their contents through any reset.
// RL11 - the control register clears on every reset and its bit 0 reads zero.
// RL12 - source select high counts the instruction clock, low counts the pin on the edge chosen by the edge select.
// RL13 - the four-bit prescale code gives 1:1 up to 1:256 in powers of two, code 0 being 1:1.
// RL14 - the count wraps from all ones to zero and sets the overflow flag, which vectoring clears.
// RL15 - prescale codes above the 1:256 code behave as 1:256.
`timescale 1ns/100ps
module pbc_base_counter16 #(
	parameter int unsigned CNT_W = 16,
	parameter int unsigned PS_W = 8
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic ext_count_pin,
	input wire logic vector_ack,
	output logic overflow_irq,
	output logic overflow_flag,
	output logic global_irq_disable,
	output logic int_pin_edge_sel
);

	if (CNT_W != 16) begin : g_chk_cnt
		$error("pbc_base_counter16: counter must be 16 bits");
	end

	if (PS_W != 8) begin : g_chk_ps
		$error("pbc_base_counter16: prescaler must be 8 bits");
	end

	// the phase counter has exactly four states, one per clock of an instruction cycle
	if (pbc_pkg::INSTR_CYC != 4) begin : g_chk_instr
		$error("pbc_base_counter16: instruction cycle must be four clocks");
	end

	// pin to count takes five or six clocks here, which must sit inside the allowed window
	if (pbc_pkg::LAT_MIN_CYC > 5 || pbc_pkg::LAT_MAX_CYC < 6) begin : g_chk_lat
		$error("pbc_base_counter16: pin to count latency outside the allowed window");
	end

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n;

	// every register on rst_n leaves reset on one edge, well clear of the pin release

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// instruction phases
	// ----------------------------------------------------------------
	pbc_pkg::pbc_phase_t phase_q;
	logic instr_tick;
	logic sample_now;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= pbc_pkg::PH_Q1;
		end else begin
			unique case (phase_q)
				pbc_pkg::PH_Q1: begin
					phase_q <= pbc_pkg::PH_Q2;
				end
				pbc_pkg::PH_Q2: begin
					phase_q <= pbc_pkg::PH_Q3;
				end
				pbc_pkg::PH_Q3: begin
					phase_q <= pbc_pkg::PH_Q4;
				end
				pbc_pkg::PH_Q4: begin
					phase_q <= pbc_pkg::PH_Q1;
				end
			endcase
		end
	end

	assign instr_tick = (phase_q == pbc_pkg::PH_Q4);
	// two sample points per instruction cycle
	assign sample_now = (phase_q == pbc_pkg::PH_Q2) || (phase_q == pbc_pkg::PH_Q4); // see RL2

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	logic wr_cc;
	logic wr_cpu;
	logic wr_irq;
	logic [1:0] wr_byte;

	// full address compare; unmapped writes fall through and change nothing
	assign wr_cc = bus_wr && (bus_addr == pbc_pkg::OFF_COUNTER_CONTROL);
	assign wr_cpu = bus_wr && (bus_addr == pbc_pkg::OFF_CPU_STATUS);
	assign wr_irq = bus_wr && (bus_addr == pbc_pkg::OFF_IRQ_STATUS_ENABLE);
	assign wr_byte[0] = bus_wr && (bus_addr == pbc_pkg::OFF_COUNT_LOW_BYTE); // see RL4
	assign wr_byte[1] = bus_wr && (bus_addr == pbc_pkg::OFF_COUNT_HIGH_BYTE); // see RL4

	// ----------------------------------------------------------------
	// counter control
	// ----------------------------------------------------------------
	logic [7:1] cc_q;
	logic ext_edge_sel;
	logic count_source_sel;
	logic [3:0] prescale_sel;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cc_q <= pbc_pkg::RST_COUNTER_CONTROL[7:1]; // see RL11
		end else if (wr_cc) begin
			// the setting may change while counting; the prescaler is not cleared by it
			cc_q <= bus_wdata[7:1]; // see RL9
		end
	end

	assign int_pin_edge_sel = cc_q[pbc_pkg::CC_INT_EDGE_BIT];
	assign ext_edge_sel = cc_q[pbc_pkg::CC_EXT_EDGE_BIT];
	assign count_source_sel = cc_q[pbc_pkg::CC_SRC_BIT];
	assign prescale_sel = cc_q[pbc_pkg::CC_PS_LSB +: pbc_pkg::CC_PS_W];

	// ----------------------------------------------------------------
	// cpu status: only the global disable lives here
	// ----------------------------------------------------------------
	logic gid_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gid_q <= pbc_pkg::RST_GLOBAL_IRQ_DISABLE;
		end else if (wr_cpu) begin
			gid_q <= bus_wdata[pbc_pkg::CPU_GID_BIT];
		end
	end

	assign global_irq_disable = gid_q;

	// ----------------------------------------------------------------
	// count source
	// ----------------------------------------------------------------
	logic ext_meta_q;
	logic ext_sync_q;
	logic ext_prev_q;
	logic ext_edge;
	logic src_edge;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_meta_q <= ext_count_pin;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_sync_q;
		end
	end

	// pin edge choice, then the prescaler; phase alignment happens after it
	always_comb begin
		if (ext_edge_sel) begin
			ext_edge = ext_sync_q && !ext_prev_q; // see RL12
		end else begin
			ext_edge = !ext_sync_q && ext_prev_q; // see RL12
		end
	end

	assign src_edge = count_source_sel ? instr_tick : ext_edge; // see RL12

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	logic cnt_wr_any;

	assign cnt_wr_any = |wr_byte;

	pbc_ps_if ps_bus ();

	assign ps_bus.src_edge = src_edge; // see RL1
	assign ps_bus.clr = cnt_wr_any; // see RL6
	assign ps_bus.sel = prescale_sel;

	pbc_prescaler #(
		.PS_W(PS_W)
	) u_prescaler (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ps(ps_bus)
	);

	// ----------------------------------------------------------------
	// phase alignment of the prescaler output
	// ----------------------------------------------------------------
	logic samp_q;
	logic inc_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_q <= 1'b0;
			inc_q <= 1'b0;
		end else if (cnt_wr_any) begin
			// the cleared prescaler reads low; forget the old sample so no false count follows
			samp_q <= 1'b0;
			inc_q <= 1'b0;
		end else if (sample_now) begin
			samp_q <= ps_bus.prescaler_output; // see RL1
			inc_q <= (ps_bus.prescaler_output != samp_q); // see RL2
		end else begin
			inc_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// count bytes
	// ----------------------------------------------------------------
	// worst path pin to count: two sync stages, edge, prescaler, up to one
	// sample wait, increment, i.e. inside the 3 to 7 period window
	logic [7:0] cnt_q [2];
	logic [2:0] inh_q [2];
	logic [1:0] byte_en;
	logic [1:0] byte_inc;
	logic ovf_evt;

	assign byte_inc[0] = inc_q && byte_en[0]; // see RL3
	// the high byte takes a carry only from a low byte at ff with no inhibit running, even one written in that cycle
	assign byte_inc[1] = inc_q && byte_en[1] && byte_en[0] && (cnt_q[0] == 8'hff);
	assign ovf_evt = byte_inc[1] && (cnt_q[1] == 8'hff); // see RL14

	for (genvar b = 0; b < 2; b++) begin : g_byte
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				inh_q[b] <= 3'h0;
			end else if (wr_byte[b]) begin
				inh_q[b] <= pbc_pkg::INHIBIT_CYC; // see RL5
			end else if (inh_q[b] != 3'h0) begin
				inh_q[b] <= inh_q[b] - 3'h1;
			end
		end

		assign byte_en[b] = (inh_q[b] == 3'h0); // see RL5

		// no reset: contents are unknown at power-up and survive later resets
		always_ff @(posedge sys_clk) begin
			if (wr_byte[b]) begin
				cnt_q[b] <= bus_wdata; // see RL10
			end else if (byte_inc[b]) begin
				cnt_q[b] <= cnt_q[b] + 8'h01; // see RL14
			end
		end
	end

	// ----------------------------------------------------------------
	// overflow flag and enables
	// ----------------------------------------------------------------
	logic flag_q;
	logic [3:0] irq_en_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= pbc_pkg::RST_OVERFLOW_FLAG;
		end else if (ovf_evt) begin
			// a wrap in the clearing cycle must not be lost
			flag_q <= 1'b1; // see RL14
		end else if (vector_ack) begin
			flag_q <= 1'b0; // see RL14
		end else if (wr_irq) begin
			flag_q <= bus_wdata[pbc_pkg::IRQ_OVF_FLAG_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_q <= pbc_pkg::RST_IRQ_ENABLES;
		end else if (wr_irq) begin
			irq_en_q <= bus_wdata[pbc_pkg::IRQ_EN_W-1:0];
		end
	end

	assign overflow_flag = flag_q;
	assign overflow_irq = flag_q && irq_en_q[pbc_pkg::IRQ_OVF_EN_BIT] && !gid_q; // see RL14

	// ----------------------------------------------------------------
	// read back
	// ----------------------------------------------------------------
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;

	// unmodelled and unimplemented bits read as zero
	always_comb begin
		rdata_d = 8'h00;
		if (bus_rd) begin
			unique case (bus_addr)
				pbc_pkg::OFF_COUNTER_CONTROL: begin
					rdata_d = {cc_q, 1'b0}; // see RL11
				end
				pbc_pkg::OFF_CPU_STATUS: begin
					rdata_d[pbc_pkg::CPU_GID_BIT] = gid_q;
				end
				pbc_pkg::OFF_IRQ_STATUS_ENABLE: begin
					rdata_d[pbc_pkg::IRQ_OVF_FLAG_BIT] = flag_q;
					rdata_d[pbc_pkg::IRQ_EN_W-1:0] = irq_en_q;
				end
				pbc_pkg::OFF_COUNT_LOW_BYTE: begin
					rdata_d = cnt_q[0]; // see RL4
				end
				pbc_pkg::OFF_COUNT_HIGH_BYTE: begin
					rdata_d = cnt_q[1]; // see RL4
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	// data only in the cycle after the read strobe, zero otherwise
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign bus_rdata = rdata_q;

endmodule : pbc_base_counter16

//--- logic/pbc_pkg.sv
package pbc_pkg;

	// ----------------------------------------------------------------
	// bus and register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] OFF_COUNTER_CONTROL = 8'h05;
	localparam logic [7:0] OFF_CPU_STATUS = 8'h06;
	localparam logic [7:0] OFF_IRQ_STATUS_ENABLE = 8'h07;
	localparam logic [7:0] OFF_COUNT_LOW_BYTE = 8'h0b;
	localparam logic [7:0] OFF_COUNT_HIGH_BYTE = 8'h0c;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CC_INT_EDGE_BIT = 7;
	localparam int unsigned CC_EXT_EDGE_BIT = 6;
	localparam int unsigned CC_SRC_BIT = 5;
	localparam int unsigned CC_PS_LSB = 1;
	localparam int unsigned CC_PS_W = 4;
	localparam logic [7:0] RST_COUNTER_CONTROL = 8'h00;
	localparam int unsigned CPU_GID_BIT = 4;
	localparam logic RST_GLOBAL_IRQ_DISABLE = 1'b1;
	localparam int unsigned IRQ_OVF_FLAG_BIT = 5;
	localparam int unsigned IRQ_OVF_EN_BIT = 1;
	localparam int unsigned IRQ_EN_W = 4;
	localparam logic [3:0] RST_IRQ_ENABLES = 4'h0;
	localparam logic RST_OVERFLOW_FLAG = 1'b0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned TOSC_NS = 5;
	localparam int unsigned TOSC_PER_INSTR = 4;
	localparam int unsigned LAT_MIN_TOSC = 3;
	localparam int unsigned LAT_MAX_TOSC = 7;
	localparam int unsigned LAT_MIN_CYC = (LAT_MIN_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LAT_MAX_CYC = (LAT_MAX_TOSC * TOSC_NS) / CLK_PERIOD_NS;
	localparam int unsigned INSTR_CYC = (TOSC_PER_INSTR * TOSC_NS) / CLK_PERIOD_NS;
	localparam logic [2:0] INHIBIT_CYC = 3'(INSTR_CYC);
	localparam logic [3:0] PS_MAX_CODE = 4'h8;

	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} pbc_phase_t;

endpackage : pbc_pkg

//--- logic/pbc_ps_if.sv
`timescale 1ns/100ps
interface pbc_ps_if;
	logic src_edge;
	logic clr;
	logic [3:0] sel;
	logic prescaler_output;

	modport ctl (
		output src_edge,
		output clr,
		output sel,
		input prescaler_output
	);

	modport ps (
		input src_edge,
		input clr,
		input sel,
		output prescaler_output
	);
endinterface : pbc_ps_if

//--- logic/pbc_prescaler.sv
`timescale 1ns/100ps
module pbc_prescaler #(
	parameter int unsigned PS_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	pbc_ps_if.ps ps
);

	if (PS_W != 8) begin : g_chk
		$error("pbc_prescaler: prescaler must be 8 bits wide");
	end

	// one extra stage so that code 8 still gives one output change per 256 edges
	logic [PS_W:0] cnt_q;
	logic [3:0] code;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (ps.clr) begin
			cnt_q <= '0; // see RL6
		end else if (ps.src_edge) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// every output change is one count, so stage k divides by 2**k
	always_comb begin
		if (ps.sel > pbc_pkg::PS_MAX_CODE) begin
			code = pbc_pkg::PS_MAX_CODE; // see RL15
		end else begin
			code = ps.sel; // see RL13
		end
	end

	assign ps.prescaler_output = cnt_q[code];

endmodule : pbc_prescaler

//--- testbench/pbc_base_counter16_props.sv
`timescale 1ns/100ps
module pbc_base_counter16_props #(
	parameter int unsigned CNT_W = 16,
	parameter int unsigned PS_W = 8
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic ext_count_pin,
	input wire logic vector_ack,
	input wire logic overflow_irq,
	input wire logic overflow_flag,
	input wire logic global_irq_disable,
	input wire logic int_pin_edge_sel
);
	// ----
	// bus and flag relations
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	chk_rd_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
		else $error("read data not zero outside a read");
	chk_unmapped_rd: assert property (bus_rd && bus_addr == 8'h08 |=> bus_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_ctl_bit0: assert property (bus_rd && bus_addr == pbc_pkg::OFF_COUNTER_CONTROL |=> !bus_rdata[0])
		else $error("control bit 0 not zero");
	chk_ctl_back: assert property (bus_wr && bus_addr == pbc_pkg::OFF_COUNTER_CONTROL ##2
		bus_rd && bus_addr == pbc_pkg::OFF_COUNTER_CONTROL |=> bus_rdata == ($past(bus_wdata, 3) & 8'hfe))
		else $error("control read back wrong");
	chk_low_hold: assert property (bus_wr && bus_addr == pbc_pkg::OFF_COUNT_LOW_BYTE ##2
		bus_rd && bus_addr == pbc_pkg::OFF_COUNT_LOW_BYTE |=> bus_rdata == $past(bus_wdata, 3))
		else $error("written low byte moved");
	chk_flag_keep: assert property (overflow_flag && !vector_ack && !bus_wr |=> overflow_flag)
		else $error("overflow flag lost");
	chk_irq_gate: assert property (overflow_irq |-> overflow_flag && !global_irq_disable)
		else $error("irq without flag or while disabled");
	chk_edge_store: assert property (bus_wr && bus_addr == pbc_pkg::OFF_COUNTER_CONTROL |=>
		int_pin_edge_sel == $past(bus_wdata[7]))
		else $error("edge select not stored");
	chk_gid_store: assert property (bus_wr && bus_addr == pbc_pkg::OFF_CPU_STATUS |=>
		global_irq_disable == $past(bus_wdata[4]))
		else $error("global disable not stored");
endmodule : pbc_base_counter16_props
bind pbc_base_counter16 pbc_base_counter16_props #(.CNT_W(CNT_W), .PS_W(PS_W)) i_props (.sys_clk, .rstn,
	.bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .ext_count_pin, .vector_ack, .overflow_irq,
	.overflow_flag, .global_irq_disable, .int_pin_edge_sel);

//--- testbench/pbc_ext_clk_src.sv
`timescale 1ns/100ps
module pbc_ext_clk_src (
	input wire logic sys_clk,
	output logic pin
);
	// ----
	// pin driver
	// ----
	initial pin = 1'b0;
	// edges land on a clock edge and hold whole cycles, so spacing is exact
	task automatic edge_to(input logic lvl, input int hold);
		@(posedge sys_clk);
		pin <= lvl;
		repeat (hold) @(posedge sys_clk);
	endtask : edge_to
	task automatic pulses(input int n, input int half);
		repeat (n) begin
			edge_to(1'b1, half);
			edge_to(1'b0, half);
		end
	endtask : pulses
endmodule : pbc_ext_clk_src

//--- testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	localparam logic [7:0] A_CC = pbc_pkg::OFF_COUNTER_CONTROL;
	localparam logic [7:0] A_CPU = pbc_pkg::OFF_CPU_STATUS;
	localparam logic [7:0] A_IRQ = pbc_pkg::OFF_IRQ_STATUS_ENABLE;
	localparam logic [7:0] A_LO = pbc_pkg::OFF_COUNT_LOW_BYTE;
	localparam logic [7:0] A_HI = pbc_pkg::OFF_COUNT_HIGH_BYTE;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic vector_ack = 1'b0;
	logic [7:0] bus_rdata;
	logic ext_count_pin;
	logic overflow_irq;
	logic overflow_flag;
	logic global_irq_disable;
	logic int_pin_edge_sel;
	int error_cnt = 0;
	int n_tests = 0;
	logic [31:0] seed = 32'hec91;
	logic [7:0] d;
	logic [7:0] v;
	logic [15:0] w;
	logic [15:0] w2;
	always #2.5 sys_clk = ~sys_clk;
	pbc_base_counter16 i_pbc_base_counter16 (.sys_clk, .rstn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
		.bus_rdata, .ext_count_pin, .vector_ack, .overflow_irq, .overflow_flag, .global_irq_disable,
		.int_pin_edge_sel);
	pbc_ext_clk_src i_pbc_ext_clk_src (.sys_clk, .pin(ext_count_pin));
	// ----
	// helpers
	// ----
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	// codes past the largest ratio behave as the largest
	function automatic int exp_cnt(int code, int ticks);
		return ticks >> (code > 8 ? 8 : code);
	endfunction : exp_cnt
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge sys_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= x;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] x);
		@(posedge sys_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 x = bus_rdata;
	endtask : rd
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic chk_rng(input logic [7:0] got, input int lo, input int hi, input string m);
		n_tests++;
		if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %0d not in %0d..%0d", $time, m, got, lo, hi);
		end
	endtask : chk_rng
	task automatic load16(input logic [15:0] x);
		wr(A_CPU, 8'h10);
		wr(A_LO, x[7:0]);
		wr(A_HI, x[15:8]);
		wr(A_CPU, 8'h00);
	endtask : load16
	task automatic read16(output logic [15:0] x);
		logic [7:0] again;
		rd(A_LO, x[7:0]);
		rd(A_HI, x[15:8]);
		rd(A_LO, again);
		if (again < x[7:0]) begin
			rd(A_LO, x[7:0]);
			rd(A_HI, x[15:8]);
		end
	endtask : read16
	task automatic do_reset();
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask : do_reset
	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask : end_test
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	// ----
	// tests
	// ----
	initial begin
		#100us;
		error_cnt++;
		print_verdict();
	end
	initial begin
		do_reset();
		rd(A_CC, d);
		chk(d, 8'h00, "control reset");
		rd(A_CPU, d);
		chk(d, 8'h10, "status reset");
		end_test("reset");
		repeat (6) begin
			v = rnd();
			wr(A_CC, v);
			rd(A_CC, d);
			chk(d, v & 8'hfe, "control");
			chk({7'h00, int_pin_edge_sel}, {7'h00, v[7]}, "edge sel");
			wr(8'h08, v);
			rd(8'h08, d);
			chk(d, 8'h00, "unmapped");
		end
		end_test("control");
		wr(A_CC, 8'h40);
		repeat (10) @(posedge sys_clk);
		load16(16'h0000);
		repeat (8) @(posedge sys_clk);
		fork
			i_pbc_ext_clk_src.edge_to(1'b1, 4);
			begin
				repeat (2) @(posedge sys_clk);
				rd(A_LO, d);
				chk(d, 8'h00, "too early");
				repeat (3) @(posedge sys_clk);
				rd(A_LO, d);
				chk(d, 8'h01, "too late");
			end
		join
		i_pbc_ext_clk_src.edge_to(1'b0, 10);
		rd(A_LO, d);
		chk(d, 8'h01, "falling ignored");
		wr(A_CC, 8'h00);
		repeat (10) @(posedge sys_clk);
		wr(A_LO, 8'h01);
		i_pbc_ext_clk_src.pulses(1, 10);
		rd(A_LO, d);
		chk(d, 8'h02, "falling counted");
		wr(A_LO, 8'h00);
		wr(A_CC, 8'h02);
		i_pbc_ext_clk_src.pulses(4, 6);
		rd(A_LO, d);
		chk(d, 8'h02, "prescaled pin");
		i_pbc_ext_clk_src.pulses(1, 6);
		wr(A_HI, 8'h00);
		i_pbc_ext_clk_src.pulses(1, 6);
		rd(A_LO, d);
		chk(d, 8'h02, "write clears prescaler");
		end_test("external");
		for (int c = 0; c < 10; c++) begin
			wr(A_LO, 8'h00);
			rd(A_LO, d);
			chk(d, 8'h00, "write holds");
			wr(A_CC, 8'h20 | 8'(c << 1));
			repeat (512) @(posedge sys_clk);
			rd(A_LO, d);
			chk_rng(d, exp_cnt(c, 128) - 2, exp_cnt(c, 128) + 3, "rate");
		end
		end_test("prescale");
		wr(A_CC, 8'h20);
		wr(A_IRQ, 8'h02);
		load16(16'hfffe);
		repeat (30) @(posedge sys_clk);
		#1;
		chk({7'h00, overflow_flag}, 8'h01, "flag set");
		chk({7'h00, overflow_irq}, 8'h01, "irq");
		rd(A_IRQ, d);
		chk(d, 8'h22, "flag read");
		wr(A_CPU, 8'h10);
		chk({7'h00, overflow_irq}, 8'h00, "masked");
		chk({7'h00, global_irq_disable}, 8'h01, "disable out");
		@(posedge sys_clk);
		vector_ack <= 1'b1;
		@(posedge sys_clk);
		vector_ack <= 1'b0;
		#1;
		chk({7'h00, overflow_flag}, 8'h00, "ack clears");
		read16(w);
		chk(w[15:8], 8'h00, "wrapped high");
		end_test("overflow");
		wr(A_CC, 8'h00);
		repeat (10) @(posedge sys_clk);
		w = {rnd(), rnd()};
		load16(w);
		do_reset();
		read16(w2);
		chk(w2[7:0], w[7:0], "kept low");
		chk(w2[15:8], w[15:8], "kept high");
		rd(A_CC, d);
		chk(d, 8'h00, "control cleared");
		end_test("reset keep");
		print_verdict();
	end
endmodule : tb_top
